// ### usfl_consts.svh
// Purpose: Constants of the serial status flag block
// Assumes: 50 MHz clock, 16-bit register port
// Notes: Offsets are word indices on the register port
`ifndef USFL_CONSTS_SVH
`define USFL_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define USFL_ADDR_W 4
`define USFL_DATA_W 16
`define USFL_OFS_STATUS 4'h0
`define USFL_OFS_RXBUF 4'h1
`define USFL_OFS_TXBUF 4'h2
`define USFL_OFS_CTRL 4'h3
`define USFL_OFS_IRQ_STAT 4'h4
`define USFL_OFS_IRQ_MASK 4'h5
`define USFL_OFS_BIT_PER 4'h6

// ****************************************************************
// Field positions
// ****************************************************************
`define USFL_SR_RX_BUFFER_FULL_FLAG 0
`define USFL_SR_OVERRUN_FLAG 1
`define USFL_SR_PERR 2
`define USFL_SR_FERR 3
`define USFL_SR_TX_BUSY_FLAG 4
`define USFL_SR_TX_BUFFER_FULL_FLAG 5
`define USFL_IRQ_RX 0
`define USFL_IRQ_TX 1
`define USFL_CTRL_IR_EN 0

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define USFL_CTRL_RST 1'h0
`define USFL_MASK_RST 2'h0
`define USFL_CLK_HZ 50000000
`define USFL_BAUD_DEF 115200
`define USFL_BIT_CYC_DEF (`USFL_CLK_HZ / `USFL_BAUD_DEF)
`define USFL_IR_NUM 3
`define USFL_IR_DEN 16
`define USFL_IR_PULSE_REF_NS 1630

`endif

// ### usfl_pkg.sv
// Purpose: Types of the serial status flag block
// Assumes: Included constants give widths
// Notes: Transmit sequencing state only
package usfl_pkg;
   typedef enum logic [1:0] {
      USFL_TX_IDLE = 2'b01,
      USFL_TX_BUSY = 2'b10
   } usfl_tx_state_e;
endpackage : usfl_pkg

// ### usfl_rx_if.sv
// Purpose: Carrier between register side and receive flag logic
// Assumes: One clock domain
// Notes: Pulses are one cycle wide
`timescale 1ns/1ps
interface usfl_rx_if;
   logic char_done;
   logic [7:0] char_data;
   logic par_bad;
   logic stop_bad;
   logic sr_rd;
   logic buf_rd;
   logic full;
   logic ovr;
   logic perr;
   logic ferr;
   logic [7:0] data;
   logic irq;
   modport ctl (output char_done, char_data, par_bad, stop_bad, sr_rd,
      buf_rd, input full, ovr, perr, ferr, data, irq);
   modport flags (input char_done, char_data, par_bad, stop_bad, sr_rd,
      buf_rd, output full, ovr, perr, ferr, data, irq);
endinterface : usfl_rx_if

// ### usfl_rx_flags.sv
// Purpose: Receive buffer and its status flags
// Assumes: Status and buffer reads are never in one cycle
// Notes: Clearing is armed by a status read that saw the flag set
`timescale 1ns/1ps
module usfl_rx_flags (
   input wire logic i_mclk,
   input wire logic i_nrst,
   usfl_rx_if.flags bus
);
   logic full, ovr, perr, ferr, irq;
   logic arm_full, arm_ovr, arm_perr, arm_ferr;
   logic [7:0] data;

   // ****************************************************************
   // Clear and accept decode
   // ****************************************************************
   wire clr_full = bus.buf_rd & arm_full;
   wire clr_ovr = bus.buf_rd & arm_ovr;
   wire clr_perr = bus.buf_rd & arm_perr;
   wire clr_ferr = bus.buf_rd & arm_ferr;
   // Buffer freed by a read in this cycle can take the new character
   wire eff_full = full & ~clr_full;
   wire accept = bus.char_done & ~eff_full;
   wire overrun = bus.char_done & eff_full;
   wire ovr_held = ovr & ~clr_ovr;
   // Set wins over clear throughout
   wire next_full = accept | eff_full;
   wire next_ovr = overrun | ovr_held;
   // Discarded characters never touch the error flags
   wire next_perr = (accept & bus.par_bad) | (perr & ~clr_perr);
   wire next_ferr = (accept & bus.stop_bad) | (ferr & ~clr_ferr);
   wire next_irq = accept | (overrun & ~ovr_held);

   // ****************************************************************
   // Flag registers
   // ****************************************************************
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         full <= 1'b0;
         ovr <= 1'b0;
         perr <= 1'b0;
         ferr <= 1'b0;
         irq <= 1'b0;
      end else begin
         full <= next_full;
         ovr <= next_ovr;
         perr <= next_perr;
         ferr <= next_ferr;
         irq <= next_irq;
      end
   end

   // Arms only catch flags seen by this status read
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         arm_full <= 1'b0;
         arm_ovr <= 1'b0;
         arm_perr <= 1'b0;
         arm_ferr <= 1'b0;
      end else if (bus.sr_rd) begin
         arm_full <= full;
         arm_ovr <= ovr;
         arm_perr <= perr;
         arm_ferr <= ferr;
      end else if (bus.buf_rd) begin
         arm_full <= 1'b0;
         arm_ovr <= 1'b0;
         arm_perr <= 1'b0;
         arm_ferr <= 1'b0;
      end
   end

   // Overrun character dropped, held one kept
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         data <= 8'h00;
      end else if (accept) begin
         data <= bus.char_data;
      end
   end

   assign bus.full = full;
   assign bus.ovr = ovr;
   assign bus.perr = perr;
   assign bus.ferr = ferr;
   assign bus.data = data;
   assign bus.irq = irq;
endmodule : usfl_rx_flags

// ### usfl_ir_pulse.sv
// Purpose: Infrared transmit pulse of three sixteenths of a bit
// Assumes: Bit period given in clock cycles
// Notes: Length rounds up, never below one cycle
`timescale 1ns/1ps
`include "usfl_consts.svh"
module usfl_ir_pulse #(
   parameter int PER_W = 16
) (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_start,
   input wire logic [PER_W-1:0] i_period,
   output logic o_pulse
);
   logic [PER_W+1:0] cnt;
   logic pulse;

   // ****************************************************************
   // Pulse length
   // ****************************************************************
   function automatic logic [PER_W+1:0] ir_len(input logic [PER_W-1:0] p);
      logic [PER_W+5:0] prod;
      prod = ({6'h00, p} * (PER_W+6)'(`USFL_IR_NUM))
         + (PER_W+6)'(`USFL_IR_DEN - 1);
      ir_len = prod[PER_W+5:4];
      if (ir_len == '0) begin
         ir_len = (PER_W+2)'(1);
      end
   endfunction : ir_len

   wire [PER_W+1:0] len = ir_len(i_period);
   wire load = i_start;
   wire [PER_W+1:0] next_cnt = load ? len - (PER_W+2)'(1) :
      (cnt != '0) ? cnt - (PER_W+2)'(1) : cnt;
   wire next_pulse = load | (cnt != '0);

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt <= '0;
         pulse <= 1'b0;
      end else begin
         cnt <= next_cnt;
         pulse <= next_pulse;
      end
   end

   assign o_pulse = pulse;
endmodule : usfl_ir_pulse

// ### usfl_top.sv
// Purpose: Status flags, buffers and interrupts of an async serial port
// Assumes: Framing, shifting and baud logic run on the same clock
// Notes: Register reads answer one cycle after the read strobe
`timescale 1ns/1ps
`include "usfl_consts.svh"
module usfl_top #(
   parameter int PER_W = 16,
   parameter logic [15:0] BIT_CYC_DEF = 16'(`USFL_BIT_CYC_DEF)
) (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic [`USFL_ADDR_W-1:0] i_addr,
   input wire logic [`USFL_DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [`USFL_DATA_W-1:0] o_rdata,
   input wire logic i_rx_char_done,
   input wire logic [7:0] i_rx_char,
   input wire logic i_rx_par_bad,
   input wire logic i_rx_stop_bad,
   input wire logic i_tx_char_done,
   input wire logic i_tx_bit_start,
   input wire logic i_tx_bit_value,
   output logic o_tx_load,
   output logic [7:0] o_tx_shift_data,
   output logic o_ir_txd,
   output logic o_rx_interrupt_request,
   output logic o_tx_interrupt_request,
   output logic o_irq
);

   // ****************************************************************
   // Register access decode
   // ****************************************************************
   wire sel_status = (i_addr == `USFL_OFS_STATUS);
   wire sel_rxbuf = (i_addr == `USFL_OFS_RXBUF);
   wire sel_txbuf = (i_addr == `USFL_OFS_TXBUF);
   wire sel_ctrl = (i_addr == `USFL_OFS_CTRL);
   wire sel_istat = (i_addr == `USFL_OFS_IRQ_STAT);
   wire sel_imask = (i_addr == `USFL_OFS_IRQ_MASK);
   wire sel_per = (i_addr == `USFL_OFS_BIT_PER);

   wire sr_rd = i_rd & sel_status;
   wire buf_rd = i_rd & sel_rxbuf;
   wire tx_wr = i_wr & sel_txbuf;

   // ****************************************************************
   // Receive side
   // ****************************************************************
   usfl_rx_if rx_bus ();

   assign rx_bus.char_done = i_rx_char_done;
   assign rx_bus.char_data = i_rx_char;
   assign rx_bus.par_bad = i_rx_par_bad;
   assign rx_bus.stop_bad = i_rx_stop_bad;
   assign rx_bus.sr_rd = sr_rd;
   assign rx_bus.buf_rd = buf_rd;

   usfl_rx_flags u_rx (
      .i_mclk (i_mclk),
      .i_nrst (i_nrst),
      .bus (rx_bus.flags)
   );

   // ****************************************************************
   // Transmit side
   // ****************************************************************
   usfl_pkg::usfl_tx_state_e tx_state;
   logic [7:0] tx_data_buffer;
   logic tx_buffer_full_flag;
   logic tx_load;
   logic [7:0] tx_shift_data;
   logic tx_irq;

   wire tx_busy_flag = (tx_state == usfl_pkg::USFL_TX_BUSY);
   // Shift register free when idle or when its character just ended
   wire shift_free = ~tx_busy_flag | i_tx_char_done;
   wire next_tx_load = tx_buffer_full_flag & shift_free;

   usfl_pkg::usfl_tx_state_e next_tx_state;
   always_comb begin
      next_tx_state = tx_state;
      unique case (tx_state)
         usfl_pkg::USFL_TX_IDLE: begin
            if (next_tx_load) begin
               next_tx_state = usfl_pkg::USFL_TX_BUSY;
            end
         end
         usfl_pkg::USFL_TX_BUSY: begin
            if (i_tx_char_done && !tx_buffer_full_flag) begin
               next_tx_state = usfl_pkg::USFL_TX_IDLE;
            end
         end
         default: begin
            next_tx_state = usfl_pkg::USFL_TX_IDLE;
         end
      endcase
   end

   // A write in the load cycle refills: set wins over the clear
   wire next_tx_buffer_full_flag = tx_wr | (tx_buffer_full_flag & ~next_tx_load);

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         tx_state <= usfl_pkg::USFL_TX_IDLE;
         tx_buffer_full_flag <= 1'b0;
         tx_load <= 1'b0;
         tx_irq <= 1'b0;
      end else begin
         tx_state <= next_tx_state;
         tx_buffer_full_flag <= next_tx_buffer_full_flag;
         tx_load <= next_tx_load;
         tx_irq <= next_tx_load;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         tx_data_buffer <= 8'h00;
      end else if (tx_wr) begin
         tx_data_buffer <= i_wdata[7:0];
      end
   end

   // Old content leaves before a same-cycle write replaces it
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         tx_shift_data <= 8'h00;
      end else if (next_tx_load) begin
         tx_shift_data <= tx_data_buffer;
      end
   end

   // ****************************************************************
   // Control and infrared
   // ****************************************************************
   logic ctrl_ir_en;
   logic [PER_W-1:0] bit_per;
   logic ir_pulse;

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl_ir_en <= `USFL_CTRL_RST;
         bit_per <= BIT_CYC_DEF[PER_W-1:0];
      end else if (i_wr) begin
         if (sel_ctrl) begin
            ctrl_ir_en <= i_wdata[`USFL_CTRL_IR_EN];
         end
         if (sel_per) begin
            bit_per <= i_wdata[PER_W-1:0];
         end
      end
   end

   // Infrared signals a zero bit with a short pulse
   wire ir_start = ctrl_ir_en & i_tx_bit_start & ~i_tx_bit_value;

   usfl_ir_pulse #(
      .PER_W (PER_W)
   ) u_ir (
      .i_mclk (i_mclk),
      .i_nrst (i_nrst),
      .i_start (ir_start),
      .i_period (bit_per),
      .o_pulse (ir_pulse)
   );

   // ****************************************************************
   // Interrupt status and mask
   // ****************************************************************
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   logic irq;

   wire [1:0] irq_evt = {tx_irq, rx_bus.irq};
   wire [1:0] irq_clr = (i_wr & sel_istat) ? i_wdata[1:0] : 2'h0;
   // New event beats a write-one clear in the same cycle
   wire [1:0] next_irq_stat = irq_evt | (irq_stat & ~irq_clr);
   wire [1:0] next_irq_mask = (i_wr & sel_imask) ? i_wdata[1:0] : irq_mask;
   wire next_irq = |(next_irq_stat & next_irq_mask);

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_stat <= 2'h0;
         irq_mask <= `USFL_MASK_RST;
         irq <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         irq <= next_irq;
      end
   end

   // ****************************************************************
   // Read data
   // ****************************************************************
   logic [`USFL_DATA_W-1:0] rdata;
   logic [`USFL_DATA_W-1:0] status_word;

   always_comb begin
      status_word = '0;
      status_word[`USFL_SR_RX_BUFFER_FULL_FLAG] = rx_bus.full;
      status_word[`USFL_SR_OVERRUN_FLAG] = rx_bus.ovr;
      status_word[`USFL_SR_PERR] = rx_bus.perr;
      status_word[`USFL_SR_FERR] = rx_bus.ferr;
      status_word[`USFL_SR_TX_BUSY_FLAG] = tx_busy_flag;
      status_word[`USFL_SR_TX_BUFFER_FULL_FLAG] = tx_buffer_full_flag;
   end

   wire [`USFL_DATA_W-1:0] rd_mux =
      sel_status ? status_word :
      sel_rxbuf ? {8'h00, rx_bus.data} :
      sel_txbuf ? {8'h00, tx_data_buffer} :
      sel_ctrl ? {15'h0000, ctrl_ir_en} :
      sel_istat ? {14'h0000, irq_stat} :
      sel_imask ? {14'h0000, irq_mask} :
      sel_per ? 16'(bit_per) : 16'h0000;

   // Answer stands only in the cycle after the strobe
   wire [`USFL_DATA_W-1:0] next_rdata = i_rd ? rd_mux : 16'h0000;

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         rdata <= 16'h0000;
      end else begin
         rdata <= next_rdata;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign o_rdata = rdata;
   assign o_tx_load = tx_load;
   assign o_tx_shift_data = tx_shift_data;
   assign o_ir_txd = ir_pulse;
   assign o_rx_interrupt_request = rx_bus.irq;
   assign o_tx_interrupt_request = tx_irq;
   assign o_irq = irq;

endmodule : usfl_top

// ### usfl_top_properties.sv
// Purpose: Port-level properties of the serial status flag block
// Assumes: One clock, bound to usfl_top
// Notes: Helpers mirror the written bit period and irq mask
`timescale 1ns/1ps
`include "usfl_consts.svh"
module usfl_checker #(
   parameter logic [15:0] BIT_CYC_DEF = 16'(`USFL_BIT_CYC_DEF)
) (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic [`USFL_ADDR_W-1:0] i_addr,
   input wire logic [`USFL_DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [`USFL_DATA_W-1:0] o_rdata,
   input wire logic i_rx_char_done,
   input wire logic i_tx_bit_start,
   input wire logic i_tx_bit_value,
   input wire logic o_tx_load,
   input wire logic o_ir_txd,
   input wire logic o_rx_interrupt_request,
   input wire logic o_tx_interrupt_request,
   input wire logic o_irq
);
   logic [15:0] per;
   logic [1:0] mask;
   logic [15:0] hi_cnt;
   logic [19:0] ir_raw;
   logic [19:0] ir_len;
   logic st_rd;
   // Rounded up, never below one cycle
   assign ir_raw = (20'(per) * 20'h3 + 20'hF) >> 4;
   assign ir_len = (ir_raw == 20'h0) ? 20'h1 : ir_raw;
   assign st_rd = i_rd && (i_addr == `USFL_OFS_STATUS);
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         per <= BIT_CYC_DEF;
         mask <= `USFL_MASK_RST;
         hi_cnt <= 16'h0;
      end else begin
         if (i_wr && i_addr == `USFL_OFS_BIT_PER) per <= i_wdata;
         if (i_wr && i_addr == `USFL_OFS_IRQ_MASK) mask <= i_wdata[1:0];
         hi_cnt <= o_ir_txd ? hi_cnt + 16'h1 : 16'h0;
      end
   end
   // ****************************************************
   // Properties
   // ****************************************************
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);
   rx_irq_cause_a: assert property (
      o_rx_interrupt_request |-> $past(i_rx_char_done))
      else $error("rx irq without a finished character");
   tx_irq_pair_a: assert property (
      o_tx_interrupt_request == o_tx_load)
      else $error("tx irq apart from shift load");
   rx_full_seen_a: assert property (
      o_rx_interrupt_request && st_rd |=> o_rdata[`USFL_SR_RX_BUFFER_FULL_FLAG])
      else $error("buffer full not set with rx irq");
   tx_busy_seen_a: assert property (
      o_tx_load && st_rd |=> o_rdata[`USFL_SR_TX_BUSY_FLAG])
      else $error("tx busy not set at shift load");
   irq_level_a: assert property (
      (o_rx_interrupt_request && mask[0])
      || (o_tx_interrupt_request && mask[1]) |=> o_irq)
      else $error("unmasked event left irq low");
   ir_start_a: assert property (
      $rose(o_ir_txd) |-> $past(i_tx_bit_start && !i_tx_bit_value))
      else $error("ir pulse without a low bit start");
   ir_width_a: assert property (
      $fell(o_ir_txd) |-> 20'(hi_cnt) == ir_len)
      else $error("ir pulse width wrong");
   rdata_idle_a: assert property (
      !$past(i_rd) |-> o_rdata == 16'h0)
      else $error("read data outside answer cycle");
endmodule : usfl_checker

bind usfl_top usfl_checker #(.BIT_CYC_DEF(BIT_CYC_DEF)) usfl_checker_i (
   .i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .i_rx_char_done(i_rx_char_done), .i_tx_bit_start(i_tx_bit_start),
   .i_tx_bit_value(i_tx_bit_value), .o_tx_load(o_tx_load),
   .o_ir_txd(o_ir_txd), .o_rx_interrupt_request(o_rx_interrupt_request),
   .o_tx_interrupt_request(o_tx_interrupt_request), .o_irq(o_irq));

// ### usfl_node.sv
// Purpose: Remote serial node behind the flag block
// Assumes: Framing reduced to character and bit pulses
// Notes: Released lines show the inverse of the last value
`timescale 1ns/1ps
module usfl_node #(
   parameter int BITC = 16
) (
   input wire logic i_mclk,
   input wire logic i_tx_load,
   input wire logic [7:0] i_tx_data,
   output logic o_rx_done,
   output logic [7:0] o_rx_char,
   output logic o_par_bad,
   output logic o_stop_bad,
   output logic o_tx_done,
   output logic o_bit_start,
   output logic o_bit_val
);
   logic [7:0] sent[$];
   logic [7:0] d;
   initial begin
      o_rx_done = 1'b0;
      o_rx_char = 8'h00;
      o_par_bad = 1'b0;
      o_stop_bad = 1'b0;
      o_tx_done = 1'b0;
      o_bit_start = 1'b0;
      o_bit_val = 1'b1;
   end
   task automatic send(input logic [7:0] c, input logic p, input logic s);
      @(posedge i_mclk);
      o_rx_done <= 1'b1;
      o_rx_char <= c;
      o_par_bad <= p;
      o_stop_bad <= s;
      @(posedge i_mclk);
      o_rx_done <= 1'b0;
      o_rx_char <= ~c;
      o_par_bad <= ~p;
      o_stop_bad <= ~s;
   endtask : send
   // Start bit, eight data bits from bit 0, one stop bit
   always begin
      @(posedge i_mclk);
      if (i_tx_load) begin
         d = i_tx_data;
         sent.push_back(d);
         for (int i = 0; i < 10; i++) begin
            o_bit_start <= 1'b1;
            o_bit_val <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
            @(posedge i_mclk);
            o_bit_start <= 1'b0;
            o_bit_val <= ~o_bit_val;
            repeat (BITC - 1) @(posedge i_mclk);
         end
         o_tx_done <= 1'b1;
         @(posedge i_mclk);
         o_tx_done <= 1'b0;
      end
   end
endmodule : usfl_node

// ### usfl_top_bench.sv
// Purpose: Self-checking bench of the serial status flag block
// Assumes: Bit period written small to keep frames short
// Notes: Expected values come from bench literals and functions
`timescale 1ns/1ps
`include "usfl_consts.svh"
module usfl_top_bench;
   localparam int BITC = 16;
   logic i_mclk, i_nrst, i_wr, i_rd, rx_done, par, stp, tx_done;
   logic bit_s, bit_v, tx_load, ir, rx_irq, tx_irq, irq, ir_q;
   logic [3:0] i_addr;
   logic [15:0] i_wdata, o_rdata;
   logic [7:0] rx_c, tx_d, a, b;
   logic [31:0] seed;
   int fails, n_compared, n_rx, n_tx, n_ir;
   usfl_top usfl_top_i (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_rx_char_done(rx_done), .i_rx_char(rx_c), .i_rx_par_bad(par),
      .i_rx_stop_bad(stp), .i_tx_char_done(tx_done),
      .i_tx_bit_start(bit_s), .i_tx_bit_value(bit_v), .o_tx_load(tx_load),
      .o_tx_shift_data(tx_d), .o_ir_txd(ir),
      .o_rx_interrupt_request(rx_irq), .o_tx_interrupt_request(tx_irq),
      .o_irq(irq));
   usfl_node #(.BITC(BITC)) usfl_node_i (.i_mclk(i_mclk),
      .i_tx_load(tx_load), .i_tx_data(tx_d), .o_rx_done(rx_done),
      .o_rx_char(rx_c), .o_par_bad(par), .o_stop_bad(stp),
      .o_tx_done(tx_done), .o_bit_start(bit_s), .o_bit_val(bit_v));
   // ****************************************************
   // Helpers
   // ****************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   // Low bits of a frame: start bit plus zero data bits
   function automatic int zeros(input logic [7:0] x);
      int n;
      n = 1;
      for (int i = 0; i < 8; i++) n += int'(!x[i]);
      return n;
   endfunction : zeros
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] ad, input logic [15:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= ad;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [3:0] ad, input logic [15:0] exp);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= ad;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, exp);
   endtask : rdc
   // Status read lands in the cycle of the rx irq pulse
   task automatic rx_st(input logic [7:0] c, input int k, input int e);
      fork
         usfl_node_i.send(c, k[0], k[1]);
         begin
            @(posedge i_mclk);
            rdc(`USFL_OFS_STATUS, 16'(e));
         end
      join
   endtask : rx_st
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   always @(posedge i_mclk) begin
      n_rx += int'(rx_irq === 1'b1);
      n_tx += int'(tx_irq === 1'b1);
      n_ir += int'(ir === 1'b1 && ir_q !== 1'b1);
      ir_q <= ir;
   end
   initial begin
      i_mclk = 1'b0;
      forever #10 i_mclk = ~i_mclk;
   end
   initial begin
      repeat (20000) @(posedge i_mclk);
      fails++;
      stop_test();
   end
   // ****************************************************
   // Scenarios
   // ****************************************************
   initial begin
      {i_nrst, i_wr, i_rd, i_addr, i_wdata, ir_q} = '0;
      {fails, n_compared, n_rx, n_tx, n_ir} = '0;
      seed = 32'hB5AD0378;
      repeat (12) @(posedge i_mclk);
      i_nrst <= 1'b1;
      rdc(`USFL_OFS_CTRL, 16'h0);
      rdc(`USFL_OFS_IRQ_MASK, 16'h0);
      rdc(`USFL_OFS_BIT_PER, 16'(`USFL_BIT_CYC_DEF));
      rdc(4'hF, 16'h0);
      wr(`USFL_OFS_IRQ_MASK, 16'h3);
      for (int k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         rx_st(seed[7:0], k, 1 + 4 * k);
         rdc(`USFL_OFS_RXBUF, {8'h00, seed[7:0]});
         rdc(`USFL_OFS_STATUS, 16'h0);
      end
      chk(16'(n_rx), 16'h4);
      rdc(`USFL_OFS_IRQ_STAT, 16'h1);
      chk({15'h0, irq}, 16'h1);
      wr(`USFL_OFS_IRQ_STAT, 16'h3);
      #1;
      chk({15'h0, irq}, 16'h0);
      seed = lfsr(seed);
      a = seed[7:0];
      usfl_node_i.send(a, 1'b0, 1'b0);
      usfl_node_i.send(8'h5A, 1'b1, 1'b1);
      usfl_node_i.send(8'hC3, 1'b0, 1'b0);
      chk(16'(n_rx), 16'h6);
      rdc(`USFL_OFS_STATUS, 16'h3);
      rdc(`USFL_OFS_RXBUF, {8'h00, a});
      rdc(`USFL_OFS_STATUS, 16'h0);
      usfl_node_i.send(a, 1'b0, 1'b0);
      rdc(`USFL_OFS_RXBUF, {8'h00, a});
      rdc(`USFL_OFS_STATUS, 16'h1);
      usfl_node_i.send(8'h81, 1'b0, 1'b0);
      rdc(`USFL_OFS_RXBUF, {8'h00, a});
      rdc(`USFL_OFS_STATUS, 16'h2);
      rdc(`USFL_OFS_RXBUF, {8'h00, a});
      rdc(`USFL_OFS_STATUS, 16'h0);
      wr(`USFL_OFS_IRQ_STAT, 16'h3);
      wr(`USFL_OFS_IRQ_MASK, 16'h2);
      usfl_node_i.send(a, 1'b0, 1'b0);
      // Status bit and the masked level both land a cycle after the pulse
      repeat (2) @(posedge i_mclk);
      #1;
      chk({15'h0, irq}, 16'h0);
      rdc(`USFL_OFS_IRQ_STAT, 16'h1);
      wr(`USFL_OFS_IRQ_STAT, 16'h1);
      rdc(`USFL_OFS_STATUS, 16'h1);
      rdc(`USFL_OFS_RXBUF, {8'h00, a});
      wr(`USFL_OFS_IRQ_MASK, 16'h3);
      wr(`USFL_OFS_BIT_PER, 16'(BITC));
      wr(`USFL_OFS_CTRL, 16'h1);
      seed = lfsr(seed);
      a = seed[7:0];
      b = seed[15:8];
      wr(`USFL_OFS_TXBUF, {8'h00, a});
      rdc(`USFL_OFS_STATUS, 16'h10);
      wr(`USFL_OFS_TXBUF, {8'h00, b});
      rdc(`USFL_OFS_STATUS, 16'h30);
      for (int i = 0; i < 1000 && usfl_node_i.sent.size() < 2; i++)
         @(posedge i_mclk);
      repeat (10 * BITC + 4) @(posedge i_mclk);
      rdc(`USFL_OFS_STATUS, 16'h0);
      chk({8'h00, usfl_node_i.sent[0]}, {8'h00, a});
      chk({8'h00, usfl_node_i.sent[1]}, {8'h00, b});
      chk(16'(n_tx), 16'h2);
      chk(16'(n_ir), 16'(zeros(a) + zeros(b)));
      rdc(`USFL_OFS_IRQ_STAT, 16'h2);
      stop_test();
   end
endmodule : usfl_top_bench
